// file: core/jdh_pkg.sv
// Shared constants and carrier types for the decoder host control block
package jdh_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [3:0] ADDR_QUEUE = 4'h6;
  localparam logic [3:0] ADDR_NBLK = 4'h7;
  localparam logic [3:0] ADDR_QSEL = 4'hD;
  localparam logic [3:0] ADDR_CTRL = 4'hE;
  localparam logic [3:0] ADDR_PIX = 4'hF;
  // ==========================================================
  // Control and status bit positions
  localparam int unsigned CTRL_START = 7;
  localparam int unsigned CTRL_PIXSEL = 6;
  localparam int unsigned CTRL_QCLR = 5;
  localparam int unsigned CTRL_RSTMK = 4;
  localparam int unsigned CTRL_IRQ_BLK = 3;
  localparam int unsigned CTRL_IRQ_LOW = 2;
  localparam int unsigned CTRL_IRQ_ERR = 1;
  localparam int unsigned CTRL_SOFT = 0;
  // ==========================================================
  // Reset values, levels and counts
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] QSEL_RST = 8'h00;
  localparam logic [23:0] NBLK_RST = 24'h00_0000;
  localparam int unsigned QUEUE_DEPTH = 64;
  localparam int unsigned PAGE_BYTES = 64;
  localparam logic [6:0] LOW_LEVEL = 7'h10;
  localparam logic [6:0] COEF_MAX = 7'h3F;
  localparam logic [1:0] NBLK_LAST = 2'h2;
  // ==========================================================
  // Pixel bus pacing
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned PIX_RATE_KHZ = 1250;
  localparam int unsigned PIX_DIV_CYC = CLK_KHZ / PIX_RATE_KHZ;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [3:0] addr;
    logic [7:0] data;
  } jdh_hbus_t;
  typedef struct packed {
    logic eoi;
    logic rst_mark;
    logic [2:0] rst_idx;
    logic long_code;
    logic coef_valid;
    logic [6:0] coef_idx;
    logic blk_done;
  } jdh_evt_t;
  typedef struct packed {
    logic valid;
    logic [1:0] component_type_out;
    logic [7:0] data;
  } jdh_pix_t;
endpackage

// file: core/jdh_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module jdh_mem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Read returns old data on a same-address write; callers wait a cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule
`default_nettype wire

// file: core/jdh_ctrl.sv
// Host control plane: input queue, pixel pages, control, status, interrupt
// ==========================================================
// Notes on behaviour
// - 64-byte input queue filled at one address, drained by decoder, pointer cleared on reset.
// - Input-low flag set while queue holds 16 bytes or fewer.
// - Empty queue never stalls; decoder just waits for bytes.
// - Two 64-byte pixel pages alternate between transform writes and reads.
// - Control bit 6 picks pixel bus or host bus; host mode idles pixel pins.
// - Status bit 5 marks a full block ready; block-ready pin mirrors it.
// - Control bit 7 starts decoding and self-clears after one clock.
// - Control bit 5 clears the queue pointer and self-clears after one clock.
// - Control bit 4 enables restart marker recognition.
// - Control bit 0 reinitialises status and pointers, keeps settings, self-clears.
// - Interrupt high for block-ready, input-low or error with matching enables.
// - Clearing access drops interrupt that cycle; other pending sources re-raise it.
// - Reading all three block count bytes clears the error and its interrupt.
// - Queue write clears input-low; it returns if level stays at 16 or below.
// - Reading one pixel clears block-ready and drops its pin and interrupt.
// - Error on early end or restart marker, over-long code, or index above 63.
// - During error the busy bits show the last restart marker index.
// - After error with restart markers, skip data until the next marker.
// - Status bits 7:6 show the output block's component type, as the pins.
// - Busy bits follow transform, dequantiser, entropy; entropy busy from start on.
// - Quant selector holds a 2-bit table index per component type.
// - Block count is a 24-bit down-counter per interval or per image.
`timescale 1ns/100ps
`default_nettype none
module jdh_ctrl #(
  parameter int unsigned PIX_DIV = jdh_pkg::PIX_DIV_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Host bus pins
  input wire jdh_pkg::jdh_hbus_t i_host,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_irq,
  // Pixel bus pins
  output logic [7:0] o_pixel,
  output logic [1:0] o_component_type_out,
  output logic o_pixel_oe,
  output logic o_pixel_strobe_out,
  output logic o_pixel_request_out,
  output logic o_block_done_out,
  // Entropy decoder side
  input wire logic i_q_pop,
  output logic [7:0] o_q_byte,
  output logic o_q_valid,
  input wire jdh_pkg::jdh_evt_t i_evt,
  output logic o_start,
  output logic o_skip,
  output logic o_restart_marker_enable,
  output logic [7:0] o_quant_table_selector,
  // Transform and dequantiser side
  input wire jdh_pkg::jdh_pix_t i_pix,
  output logic o_pix_ready,
  input wire logic i_transform_active,
  input wire logic i_dequant_active
);
  import jdh_pkg::*;

  // ==========================================================
  // Host pin synchronisers and access decode
  jdh_hbus_t h1_q, h2_q;
  logic rd_prev_q, wr_prev_q;
  wire rd_act = !h2_q.cs_n && !h2_q.rd_n;
  wire wr_act = !h2_q.cs_n && !h2_q.wr_n;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h1_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: 4'h0, data: 8'h00};
      h2_q <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: 4'h0, data: 8'h00};
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      h1_q <= i_host;
      h2_q <= h1_q;
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end
  wire rd_go = rd_act && !rd_prev_q;
  wire wr_go = wr_act && !wr_prev_q;
  wire [7:0] wdat = h2_q.data;
  wire q_wr_acc = wr_go && h2_q.addr == ADDR_QUEUE;
  wire nb_wr = wr_go && h2_q.addr == ADDR_NBLK;
  wire qsel_wr = wr_go && h2_q.addr == ADDR_QSEL;
  wire ctrl_wr = wr_go && h2_q.addr == ADDR_CTRL;
  wire nb_rd = rd_go && h2_q.addr == ADDR_NBLK;
  wire pix_rd = rd_go && h2_q.addr == ADDR_PIX;

  // ==========================================================
  // Control, selector and self-clearing pulses
  logic [7:0] ctrl_q, qsel_q;
  logic start_p, qclr_p, soft_p;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
      qsel_q <= QSEL_RST;
    end else begin
      if (ctrl_wr) ctrl_q <= wdat;
      else ctrl_q <= ctrl_q & ~8'hA1;
      if (qsel_wr) qsel_q <= wdat;
    end
  end
  assign start_p = ctrl_q[CTRL_START];
  assign qclr_p = ctrl_q[CTRL_QCLR];
  assign soft_p = ctrl_q[CTRL_SOFT];
  wire pix_sel = ctrl_q[CTRL_PIXSEL];
  wire rstmk_en = ctrl_q[CTRL_RSTMK];

  // ==========================================================
  // Input byte queue
  logic [5:0] q_wp_q, q_rp_q;
  logic [6:0] q_cnt_q;
  logic ent_act_q;
  wire q_full = q_cnt_q == 7'(QUEUE_DEPTH);
  wire q_we = q_wr_acc && !q_full;
  wire q_rd = i_q_pop && o_q_valid;
  wire q_flush = qclr_p || soft_p;
  wire [5:0] q_rp_d = q_flush ? 6'h00 : q_rp_q + 6'(q_rd);
  wire [6:0] q_cnt_d = q_flush ? 7'h00 : q_cnt_q + 7'(q_we) - 7'(q_rd);
  wire low_d = (q_cnt_d <= LOW_LEVEL) && !q_wr_acc;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_wp_q <= 6'h00;
      q_rp_q <= 6'h00;
      q_cnt_q <= 7'h00;
      o_q_valid <= 1'b0;
      ent_act_q <= 1'b0;
    end else begin
      q_wp_q <= q_flush ? 6'h00 : q_wp_q + 6'(q_we);
      q_rp_q <= q_rp_d;
      q_cnt_q <= q_cnt_d;
      // Valid lags one cycle so the registered read sees fresh data
      o_q_valid <= q_cnt_q != 7'h00 && !q_rd && !q_flush;
      if (soft_p) ent_act_q <= 1'b0;
      else if (start_p) ent_act_q <= 1'b1;
    end
  end
  jdh_mem #(.DEPTH(QUEUE_DEPTH), .AW(6)) u_queue (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_we(q_we),
    .i_waddr(q_wp_q),
    .i_wdata(wdat),
    .i_raddr(q_rp_d),
    .o_rdata(o_q_byte)
  );

  // ==========================================================
  // Block count, decode error and restart tracking
  logic [23:0] nblk_q, nblk_init_q;
  logic [1:0] nb_wi_q, nb_ri_q;
  logic err_q, skip_q;
  logic [2:0] rsc_q;
  wire mark_end = i_evt.eoi || (i_evt.rst_mark && rstmk_en);
  wire err_set = (mark_end && nblk_q != 24'h00_0000) || i_evt.long_code
    || (i_evt.coef_valid && i_evt.coef_idx > COEF_MAX);
  wire err_clr = nb_rd && nb_ri_q == NBLK_LAST;
  wire err_d = err_set || (err_q && !err_clr && !soft_p);
  wire [7:0] nb_rbyte = nb_ri_q == 2'h0 ? nblk_q[23:16]
    : nb_ri_q == 2'h1 ? nblk_q[15:8] : nblk_q[7:0];
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nblk_q <= NBLK_RST;
      nblk_init_q <= NBLK_RST;
      nb_wi_q <= 2'h0;
      nb_ri_q <= 2'h0;
      err_q <= 1'b0;
      skip_q <= 1'b0;
      rsc_q <= 3'h0;
    end else begin
      if (nb_wr) begin
        nb_wi_q <= nb_wi_q == NBLK_LAST ? 2'h0 : nb_wi_q + 2'h1;
        nblk_init_q <= {nblk_init_q[15:0], wdat};
        nblk_q <= {nblk_init_q[15:0], wdat};
      end else if (i_evt.rst_mark && rstmk_en) begin
        nblk_q <= nblk_init_q;
      end else if (i_evt.blk_done && nblk_q != 24'h00_0000 && !skip_q) begin
        nblk_q <= nblk_q - 24'h00_0001;
      end
      if (nb_rd) nb_ri_q <= nb_ri_q == NBLK_LAST ? 2'h0 : nb_ri_q + 2'h1;
      err_q <= err_d;
      if (i_evt.rst_mark && rstmk_en && !err_q) rsc_q <= i_evt.rst_idx;
      if (soft_p || (i_evt.rst_mark && rstmk_en)) skip_q <= 1'b0;
      else if (err_set && rstmk_en) skip_q <= 1'b1;
    end
  end
  // Settings outputs track the registers so the decoder sees a write at once
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_restart_marker_enable <= 1'b0;
      o_quant_table_selector <= QSEL_RST;
      o_start <= 1'b0;
      o_skip <= 1'b0;
    end else begin
      o_restart_marker_enable <= ctrl_wr ? wdat[CTRL_RSTMK] : rstmk_en;
      o_quant_table_selector <= qsel_wr ? wdat : qsel_q;
      o_start <= ctrl_wr && wdat[CTRL_START];
      o_skip <= skip_q;
    end
  end

  // ==========================================================
  // Ping-pong pixel pages
  logic [1:0] full_q;
  logic [1:0] pg_ct_q [2];
  logic wpg_q, rpg_q;
  logic [5:0] widx_q, ridx_q;
  logic [PIX_DIV-1:0] div_q;
  wire pix_tick = div_q[PIX_DIV-1];
  wire avail = full_q[rpg_q];
  wire px_we = i_pix.valid && o_pix_ready;
  wire wdone = px_we && widx_q == 6'(PAGE_BYTES - 1);
  wire bus_take = pix_sel && pix_tick && avail && !o_pixel_strobe_out;
  wire host_take = !pix_sel && pix_rd && avail;
  wire take = bus_take || host_take;
  wire rdone = take && ridx_q == 6'(PAGE_BYTES - 1);
  wire [5:0] ridx_d = soft_p ? 6'h00 : ridx_q + 6'(take);
  wire rpg_d = soft_p ? 1'b0 : rpg_q ^ rdone;
  wire wpg_d = soft_p ? 1'b0 : wpg_q ^ wdone;
  wire [1:0] set_m = wdone ? (wpg_q ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] clr_m = rdone ? (rpg_q ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] full_d = soft_p ? 2'b00 : (full_q & ~clr_m) | set_m;
  wire blk_d = full_d[rpg_d] && ridx_d == 6'h00;
  wire [7:0] pix_byte;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      full_q <= 2'b00;
      pg_ct_q <= '{2'h0, 2'h0};
      wpg_q <= 1'b0;
      rpg_q <= 1'b0;
      widx_q <= 6'h00;
      ridx_q <= 6'h00;
      div_q <= PIX_DIV'(1);
    end else begin
      full_q <= full_d;
      wpg_q <= wpg_d;
      rpg_q <= rpg_d;
      ridx_q <= ridx_d;
      if (soft_p) widx_q <= 6'h00;
      else if (px_we) widx_q <= widx_q + 6'h01;
      if (px_we && widx_q == 6'h00) pg_ct_q[wpg_q] <= i_pix.component_type_out;
      // One-hot ring paces the pixel bus at its documented rate
      div_q <= {div_q[PIX_DIV-2:0], div_q[PIX_DIV-1]};
    end
  end
  jdh_mem #(.DEPTH(2 * PAGE_BYTES), .AW(7)) u_pages (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_we(px_we),
    .i_waddr({wpg_q, widx_q}),
    .i_wdata(i_pix.data),
    .i_raddr({rpg_d, ridx_d}),
    .o_rdata(pix_byte)
  );

  // ==========================================================
  // Status byte, read data and interrupt
  logic blk_q, low_q;
  wire [2:0] busy = err_q ? rsc_q
    : {i_transform_active, i_dequant_active, ent_act_q};
  wire [7:0] status = {pg_ct_q[rpg_q], blk_q, busy, err_q, low_q};
  wire [7:0] rd_val = h2_q.addr == ADDR_CTRL ? status
    : h2_q.addr == ADDR_NBLK ? nb_rbyte
    : h2_q.addr == ADDR_PIX ? pix_byte : 8'h00;
  wire low_sd = soft_p ? 1'b0 : low_d;
  wire blk_sd = soft_p ? 1'b0 : blk_d;
  wire err_sd = soft_p ? 1'b0 : err_d;
  wire irq_raw = (blk_sd && ctrl_q[CTRL_IRQ_BLK]) || (low_sd && ctrl_q[CTRL_IRQ_LOW])
    || (err_sd && ctrl_q[CTRL_IRQ_ERR]);
  wire clr_acc = q_wr_acc || host_take || err_clr;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_q <= 1'b0;
      low_q <= 1'b0;
      o_irq <= 1'b0;
      o_block_done_out <= 1'b0;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      blk_q <= blk_sd;
      low_q <= low_sd;
      o_block_done_out <= blk_sd;
      o_irq <= irq_raw && !clr_acc;
      if (rd_go) o_data <= rd_val;
      o_data_oe <= rd_act;
    end
  end

  // ==========================================================
  // Pixel bus outputs
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pixel <= 8'h00;
      o_component_type_out <= 2'h0;
      o_pixel_oe <= 1'b0;
      o_pixel_strobe_out <= 1'b0;
      o_pixel_request_out <= 1'b0;
      o_pix_ready <= 1'b0;
    end else begin
      if (bus_take) o_pixel <= pix_byte;
      o_component_type_out <= bus_take ? pg_ct_q[rpg_q] : pg_ct_q[rpg_d];
      o_pixel_oe <= pix_sel;
      o_pixel_strobe_out <= bus_take;
      o_pixel_request_out <= pix_sel && full_d[rpg_d];
      o_pix_ready <= !full_d[wpg_d] && !soft_p;
    end
  end

  // ==========================================================
  // Checks
  queue_full_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    q_full && q_wr_acc && !q_rd && !q_flush |=> q_cnt_q == 7'(QUEUE_DEPTH))
    else $error("queue count moved on a write while full");
  queue_bound_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    q_cnt_q <= 7'(QUEUE_DEPTH))
    else $error("queue count above depth");
  queue_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ctrl_wr && wdat[CTRL_QCLR] |=> ##1 q_cnt_q == 7'h00 && !o_q_valid)
    else $error("queue not emptied by clear");
  low_flag_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !q_wr_acc && !soft_p && q_cnt_d <= LOW_LEVEL |=> low_q)
    else $error("input low flag missing");
  start_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ctrl_wr && wdat[CTRL_START] |=> start_p ##1 !start_p && ent_act_q)
    else $error("start bit did not self-clear");
  irq_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    clr_acc |=> !o_irq)
    else $error("interrupt high after clearing access");
  blk_mirror_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_block_done_out == blk_q)
    else $error("block ready pin differs from status");
  err_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_evt.long_code && !soft_p |=> err_q ##1 (err_q || $past(err_clr) || $past(soft_p)))
    else $error("decode error flag not set");
  pix_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !pix_sel ##1 !pix_sel |-> !o_pixel_oe && !o_pixel_strobe_out && !o_pixel_request_out)
    else $error("pixel pins active in host mode");
endmodule
`default_nettype wire

// file: testbench/jdh_host_model.sv
// Host processor model for the register bus pins
`timescale 1ns/100ps
`default_nettype none
module jdh_host_model
  import jdh_pkg::*;
(
  // Clock and read data
  input wire logic i_mclk,
  input wire logic [7:0] i_data,
  // Bus pins
  output var jdh_pkg::jdh_hbus_t o_host
);
  // ==========================================================
  // Bus cycles
  initial begin
    o_host = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
  end
  // Strobes stand six clocks to cover the two sync flops and the read register
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge i_mclk);
    o_host.addr = a;
    o_host.data = wr ? d : ~o_host.data;
    o_host.cs_n = 1'b0;
    o_host.wr_n = ~wr;
    o_host.rd_n = wr;
    repeat (6) @(negedge i_mclk);
    q = i_data;
    // Released data lines show a changed pattern, never the last byte
    o_host = '{1'b1, 1'b1, 1'b1, a, ~o_host.data};
    repeat (4) @(negedge i_mclk);
  endtask
endmodule
`default_nettype wire

// file: testbench/jdh_ctrl_tb.sv
// Self-checking bench for the decoder host control block
`timescale 1ns/100ps
`default_nettype none
module jdh_ctrl_tb;
  import jdh_pkg::*;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic q_pop = 1'b0;
  logic xf_act = 1'b0;
  logic dq_act = 1'b0;
  jdh_evt_t evt = '0;
  jdh_pix_t pix = '0;
  jdh_evt_t e;
  jdh_hbus_t host;
  logic [7:0] rdata, qbyte, pixel, qsel, v;
  logic [1:0] component_type_out;
  logic data_oe, irq, pix_oe, strobe, preq, blk, qvalid, start, skip, rme, pix_ready;
  int fail_count = 0;
  int compares = 0;
  int nstrobe = 0;
  int nstart = 0;
  int nlow = 0;
  // Rows: address, data, restart enable, pixel enable, selector
  logic [21:0] rows [5] = '{
    {4'hD, 8'hE4, 2'h0, 8'hE4},
    {4'hE, 8'h10, 2'h2, 8'hE4},
    {4'hE, 8'h40, 2'h1, 8'hE4},
    {4'hD, 8'h1B, 2'h1, 8'h1B},
    {4'hE, 8'h11, 2'h2, 8'h1B}
  };
  // ==========================================================
  // Clock, design and host
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  jdh_ctrl #(.PIX_DIV(4)) DUT (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_host(host), .o_data(rdata),
    .o_data_oe(data_oe), .o_irq(irq), .o_pixel(pixel), .o_component_type_out(component_type_out),
    .o_pixel_oe(pix_oe), .o_pixel_strobe_out(strobe), .o_pixel_request_out(preq),
    .o_block_done_out(blk), .i_q_pop(q_pop), .o_q_byte(qbyte), .o_q_valid(qvalid),
    .i_evt(evt), .o_start(start), .o_skip(skip), .o_restart_marker_enable(rme),
    .o_quant_table_selector(qsel), .i_pix(pix), .o_pix_ready(pix_ready),
    .i_transform_active(xf_act), .i_dequant_active(dq_act)
  );
  jdh_host_model u_host (.i_mclk(mclk), .i_data(rdata), .o_host(host));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d, v);
  endtask
  task automatic rd(input logic [3:0] a);
    u_host.access(1'b0, a, 8'h00, v);
  endtask
  task automatic pulse(input jdh_evt_t x);
    @(negedge mclk);
    evt = x;
    @(negedge mclk);
    evt = '0;
    repeat (3) @(negedge mclk);
  endtask
  // Extra idle cycles keep a stale valid from taking a second pop
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (qvalid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(qbyte, exp);
    q_pop = 1'b1;
    @(negedge mclk);
    q_pop = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic push_page(input logic [1:0] ct, input logic [7:0] base);
    int i;
    i = 0;
    while (i < 64) begin
      @(negedge mclk);
      pix.valid = pix_ready;
      pix.component_type_out = ct;
      pix.data = base + i[7:0];
      if (pix_ready === 1'b1) i++;
    end
    @(negedge mclk);
    pix.valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Monitors and watchdog
  always @(negedge mclk) begin
    if (start === 1'b1) nstart++;
    if (irq === 1'b0) nlow++;
    if (strobe === 1'b1) begin
      chk(pixel, 8'h80 + nstrobe[7:0]);
      chk({6'h0, component_type_out}, 8'h01);
      chk({7'h0, pix_oe}, 8'h01);
      nstrobe++;
    end
  end
  // About 2500 clocks are needed; a run far beyond that is a hang
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (12) @(negedge mclk);
    chk({irq, qvalid, start, blk, pix_oe, strobe, preq, data_oe}, 8'h00);
    rst_n = 1'b1;
    @(negedge mclk);
    rd(ADDR_CTRL);
    chk(v, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i][21:18], rows[i][17:10]);
      chk({6'h0, rme, pix_oe}, {6'h0, rows[i][9:8]});
      chk(qsel, rows[i][7:0]);
    end
    nstart = 0;
    wr(ADDR_CTRL, 8'h84);
    chk(nstart[7:0], 8'h01);
    rd(ADDR_CTRL);
    chk(v, 8'h05);
    chk({7'h0, irq}, 8'h01);
    nlow = 0;
    wr(ADDR_QUEUE, 8'hA0);
    chk({7'h0, nlow != 0}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    // One write more than the queue holds, to see it refused
    for (int i = 1; i < 65; i++) begin
      wr(ADDR_QUEUE, i[7:0]);
      if (i == 15 || i == 16) begin
        rd(ADDR_CTRL);
        chk({7'h0, v[0]}, {7'h0, i == 15});
      end
    end
    chk({7'h0, irq}, 8'h00);
    pop(8'hA0);
    for (int i = 1; i < 64; i++) pop(i[7:0]);
    repeat (4) @(negedge mclk);
    chk({7'h0, qvalid}, 8'h00);
    wr(ADDR_QUEUE, 8'h55);
    wr(ADDR_CTRL, 8'h24);
    chk({7'h0, qvalid}, 8'h00);
    rd(ADDR_CTRL);
    chk(v, 8'h05);
    wr(ADDR_CTRL, 8'h08);
    push_page(2'h2, 8'h40);
    push_page(2'h1, 8'h80);
    repeat (3) @(negedge mclk);
    chk({6'h0, blk, irq}, 8'h03);
    chk({6'h0, pix_oe, preq}, 8'h00);
    rd(ADDR_CTRL);
    chk(v, 8'hA5);
    for (int k = 0; k < 64; k++) begin
      rd(ADDR_PIX);
      chk(v, 8'h40 + k[7:0]);
      if (k == 0) chk({6'h0, blk, irq}, 8'h00);
    end
    wr(ADDR_CTRL, 8'h40);
    repeat (320) @(negedge mclk);
    chk(nstrobe[7:0], 8'h40);
    wr(ADDR_CTRL, 8'h12);
    e = '0;
    e.rst_mark = 1'b1;
    e.rst_idx = 3'h5;
    pulse(e);
    e = '0;
    e.coef_valid = 1'b1;
    e.coef_idx = COEF_MAX;
    pulse(e);
    chk({7'h0, irq}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      e = '0;
      e.coef_valid = (k == 0);
      e.coef_idx = 7'h40;
      e.long_code = (k == 1);
      pulse(e);
      chk({6'h0, irq, skip}, 8'h03);
      rd(ADDR_CTRL);
      chk({3'h0, v[4:0]}, 8'h17);
      repeat (3) rd(ADDR_NBLK);
      chk({7'h0, irq}, 8'h00);
      e = '0;
      e.rst_mark = 1'b1;
      e.rst_idx = 3'h5;
      pulse(e);
      chk({7'h0, skip}, 8'h00);
    end
    // Block count loaded MSB first, one block done, then an early end marker
    wr(ADDR_NBLK, 8'h00);
    wr(ADDR_NBLK, 8'h00);
    wr(ADDR_NBLK, 8'h02);
    e = '0;
    e.blk_done = 1'b1;
    pulse(e);
    e = '0;
    e.eoi = 1'b1;
    pulse(e);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_NBLK);
    chk(v, 8'h00);
    rd(ADDR_NBLK);
    chk(v, 8'h00);
    rd(ADDR_NBLK);
    chk(v, 8'h01);
    chk({7'h0, irq}, 8'h00);
    // Busy bits follow the transform and dequantiser levels
    xf_act = 1'b1;
    rd(ADDR_CTRL);
    chk({5'h0, v[4:2]}, 8'h05);
    xf_act = 1'b0;
    dq_act = 1'b1;
    rd(ADDR_CTRL);
    chk({5'h0, v[4:2]}, 8'h03);
    dq_act = 1'b0;
    // Hardware reset in mid-run clears pointers, status and selector
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk({irq, qvalid, start, blk, pix_oe, strobe, skip, rme}, 8'h00);
    rst_n = 1'b1;
    @(negedge mclk);
    rd(ADDR_CTRL);
    chk(v, 8'h01);
    chk(qsel, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
